//--- verilog/adc_regs_pkg.sv
// constants for the configuration, status and protection register group
// assumes one 100 MHz clock and a serial front end that turns frames into register strobes
// Notes on behaviour
// - snapshot shows latched 12-bit counter, upper bits zero
// - setup bit 0 picks clock out over ready
// - setup bit 2 shuts converter and modulators down
// - setup bit 3 picks temperature for second channel
// - two-channel variant always measures temperature
// - setup bits 5:4 pick output rate 8..1 kHz
// - soft restart bit self-clears after one cycle
// - setup bit 7 picks filter bandwidth
// - status bit 0 high while reset runs
// - status bit 1 set when config CRC changes
// - status bit 2 shows protection enabled
// - key 0xca written to lock enables protection
// - key 0x9c written to lock disables protection
// - lock register reads back as zero
// - reserved setup and status bits read zero
package adc_regs_pkg;
    localparam int ADDR_W = 5;
    localparam int DATA_W = 8;
    localparam int RDATA_W = 16;
    localparam int COUNT_W = 12;
    localparam int CRC_W = 16;

    // register offsets
    localparam logic [ADDR_W-1:0] SNAPSHOT_ADDR = 5'h07;
    localparam logic [ADDR_W-1:0] SETUP_ADDR = 5'h08;
    localparam logic [ADDR_W-1:0] STATE_ADDR = 5'h09;
    localparam logic [ADDR_W-1:0] LOCK_ADDR = 5'h0a;

    // setup fields
    localparam int CLKSEL_BIT = 0;
    localparam int SHUTDOWN_BIT = 2;
    localparam int TEMPSEL_BIT = 3;
    localparam int RATE_LSB = 4;
    localparam int RATE_MSB = 5;
    localparam int RESTART_BIT = 6;
    localparam int BANDWIDTH_BIT = 7;
    localparam logic [DATA_W-1:0] SETUP_RESET = 8'h00;
    localparam logic [DATA_W-1:0] SETUP_WMASK = 8'hfd;

    // state flag fields
    localparam int RESETON_BIT = 0;
    localparam int CRCFLAG_BIT = 1;
    localparam int PROT_BIT = 2;

    // keys
    localparam logic [DATA_W-1:0] KEY_LOCK = 8'hca;
    localparam logic [DATA_W-1:0] KEY_UNLOCK = 8'h9c;
    localparam logic [DATA_W-1:0] LOCK_READ = 8'h00;
    localparam logic [COUNT_W-1:0] SNAPSHOT_RESET = 12'h000;

    // crc over setup contents
    localparam logic [CRC_W-1:0] CRC_POLY = 16'h1021;
    localparam logic [CRC_W-1:0] CRC_SEED = 16'hffff;

    // internal reset sequence length
    localparam int CLK_PERIOD_NS = 10;
    localparam int RESET_TIME_NS = 1000;
    localparam int RESET_CYCLES = (RESET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SEQ_W = 8;

    typedef enum logic [1:0] {
        RATE_8K = 2'b00,
        RATE_4K = 2'b01,
        RATE_2K = 2'b10,
        RATE_1K = 2'b11
    } rate_e;

    typedef enum logic {
        SEQ_READY = 1'b0,
        SEQ_BUSY = 1'b1
    } seq_e;
endpackage

//--- verilog/setup_link_if.sv
// signals shared by the register bank and its helpers
// assumes all three run on the same clock
`timescale 1ns/10ps
`default_nettype none
interface setup_link_if;
    import adc_regs_pkg::*;
    logic [DATA_W-1:0] setupByte;
    logic restartPulse;
    logic resetOn;
    logic crcChanged;

    modport regs (output setupByte, output restartPulse, input resetOn, input crcChanged);
    modport seq (input restartPulse, output resetOn);
    modport crc (input setupByte, output crcChanged);
endinterface
`default_nettype wire

//--- verilog/reset_sequencer.sv
// holds the reset-in-progress flag for a fixed time after any reset
// assumes sys_rst synchronous and the restart pulse one cycle wide
`timescale 1ns/10ps
`default_nettype none
module reset_sequencer (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // link to register bank
    setup_link_if.seq link
);
    import adc_regs_pkg::*;

    localparam logic [SEQ_W-1:0] LAST_COUNT = SEQ_W'(RESET_CYCLES - 1);

    seq_e state_ff;
    logic [SEQ_W-1:0] count_ff;

    always_ff @(posedge clk) begin
        if (sys_rst || link.restartPulse) begin
            state_ff <= SEQ_BUSY;
        end else begin
            unique case (state_ff)
                SEQ_BUSY: begin
                    if (count_ff == LAST_COUNT) begin
                        state_ff <= SEQ_READY;
                    end
                end
                SEQ_READY: begin
                    state_ff <= SEQ_READY;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst || link.restartPulse || state_ff == SEQ_READY) begin
            count_ff <= '0;
        end else begin
            count_ff <= count_ff + SEQ_W'(1);
        end
    end

    assign link.resetOn = (state_ff == SEQ_BUSY);
endmodule // reset_sequencer
`default_nettype wire

//--- verilog/setup_crc_watch.sv
// keeps a crc of the setup contents and flags each change of it
// assumes the setup byte is a flip-flop output on the same clock
`timescale 1ns/10ps
`default_nettype none
module setup_crc_watch (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // link to register bank
    setup_link_if.crc link
);
    import adc_regs_pkg::*;

    function automatic logic [CRC_W-1:0] crc_byte(input logic [CRC_W-1:0] seed, input logic [DATA_W-1:0] data);
        logic [CRC_W-1:0] c;
        c = seed;
        for (int i = DATA_W - 1; i >= 0; i--) begin
            if (c[CRC_W-1] ^ data[i]) begin
                c = {c[CRC_W-2:0], 1'b0} ^ CRC_POLY;
            end else begin
                c = {c[CRC_W-2:0], 1'b0};
            end
        end
        return c;
    endfunction

    logic [CRC_W-1:0] crcNow;
    logic [CRC_W-1:0] crc_ff;
    logic primed_ff;

    assign crcNow = crc_byte(CRC_SEED, link.setupByte);

    // first sample after reset only primes, so reset itself is no change
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            primed_ff <= 1'b0;
            crc_ff <= CRC_SEED;
        end else begin
            primed_ff <= 1'b1;
            crc_ff <= crcNow;
        end
    end

    assign link.crcChanged = primed_ff && (crcNow != crc_ff);
endmodule // setup_crc_watch
`default_nettype wire

//--- verilog/adc_config_status_lock_regs.sv
// configuration, state flags, counter snapshot and write protection registers
// assumes a serial front end on clk giving one-cycle read and write strobes
`timescale 1ns/10ps
`default_nettype none
module adc_config_status_lock_regs #(
    parameter bit TWO_CHANNEL = 1'b0
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // register access from the serial front end
    input wire logic [adc_regs_pkg::ADDR_W-1:0] regAddr,
    input wire logic regWrite,
    input wire logic [adc_regs_pkg::DATA_W-1:0] regWrData,
    input wire logic regRead,
    output logic [adc_regs_pkg::RDATA_W-1:0] regRdData,
    output logic regRdValid,
    // synchronization counter
    input wire logic [adc_regs_pkg::COUNT_W-1:0] syncCount,
    input wire logic snapCapture,
    // shared pin sources and pin
    input wire logic sampleReady_n,
    input wire logic clockSource,
    output logic sharedClockOrReadyPin,
    // controls to the converter
    output logic converterShutdown,
    output logic secondChannelTemp,
    output logic [1:0] outputRateSelect,
    output logic filterBandwidthSelect,
    output logic softRestart,
    output logic restartBusy
);
    import adc_regs_pkg::*;

    setup_link_if link ();

    logic [DATA_W-1:0] setup_ff;
    logic protected_ff;
    logic crcFlag_ff;
    logic [COUNT_W-1:0] snapshot_ff;
    logic [RDATA_W-1:0] rdData_ff;
    logic rdValid_ff;
    logic pin_ff;
    logic [DATA_W-1:0] stateFlags;
    logic setupWrite;
    logic lockWrite;
    logic stateRead;
    logic [RDATA_W-1:0] nxt_rdData;

    function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [ADDR_W-1:0] target);
        return addr == target;
    endfunction

    assign lockWrite = regWrite && hit(regAddr, LOCK_ADDR);
    // setup writes during the internal reset or under protection are dropped
    assign setupWrite = regWrite && hit(regAddr, SETUP_ADDR) && !protected_ff && !link.resetOn;
    assign stateRead = regRead && hit(regAddr, STATE_ADDR);

    // setup register; restart bit lives for exactly one cycle
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            setup_ff <= SETUP_RESET;
        end else if (setup_ff[RESTART_BIT]) begin
            setup_ff <= SETUP_RESET;
        end else if (setupWrite) begin
            setup_ff <= regWrData & SETUP_WMASK;
        end
    end

    assign link.setupByte = setup_ff;
    assign link.restartPulse = setup_ff[RESTART_BIT];

    // protection state, only the two keys, reset and the restart pulse change it
    always_ff @(posedge clk) begin
        if (sys_rst || link.restartPulse) begin
            protected_ff <= 1'b0;
        end else if (lockWrite && regWrData == KEY_LOCK) begin
            protected_ff <= 1'b1;
        end else if (lockWrite && regWrData == KEY_UNLOCK) begin
            protected_ff <= 1'b0;
        end
    end

    // sticky crc flag; a change in the clearing read cycle still sets it
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            crcFlag_ff <= 1'b0;
        end else if (link.crcChanged) begin
            crcFlag_ff <= 1'b1;
        end else if (stateRead) begin
            crcFlag_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst || link.restartPulse) begin
            snapshot_ff <= SNAPSHOT_RESET;
        end else if (snapCapture) begin
            snapshot_ff <= syncCount;
        end
    end

    always_comb begin
        stateFlags = '0;
        stateFlags[RESETON_BIT] = link.resetOn;
        stateFlags[CRCFLAG_BIT] = crcFlag_ff;
        stateFlags[PROT_BIT] = protected_ff;
    end

    always_comb begin
        nxt_rdData = '0;
        unique case (1'b1)
            hit(regAddr, SNAPSHOT_ADDR): nxt_rdData = {{(RDATA_W-COUNT_W){1'b0}}, snapshot_ff};
            hit(regAddr, SETUP_ADDR): nxt_rdData = {{(RDATA_W-DATA_W){1'b0}}, setup_ff};
            hit(regAddr, STATE_ADDR): nxt_rdData = {{(RDATA_W-DATA_W){1'b0}}, stateFlags};
            hit(regAddr, LOCK_ADDR): nxt_rdData = {{(RDATA_W-DATA_W){1'b0}}, LOCK_READ};
            default: nxt_rdData = '0;
        endcase
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rdData_ff <= '0;
            rdValid_ff <= 1'b0;
        end else begin
            rdValid_ff <= regRead;
            if (regRead) begin
                rdData_ff <= nxt_rdData;
            end
        end
    end

    // pin registered so the selection never glitches it
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pin_ff <= 1'b1;
        end else begin
            pin_ff <= setup_ff[CLKSEL_BIT] ? clockSource : sampleReady_n;
        end
    end

    reset_sequencer u_seq (
        .clk(clk),
        .sys_rst(sys_rst),
        .link(link.seq)
    );

    setup_crc_watch u_crc (
        .clk(clk),
        .sys_rst(sys_rst),
        .link(link.crc)
    );

    assign regRdData = rdData_ff;
    assign regRdValid = rdValid_ff;
    assign sharedClockOrReadyPin = pin_ff;
    assign converterShutdown = setup_ff[SHUTDOWN_BIT];
    // smaller variant has no second input pair to measure
    assign secondChannelTemp = TWO_CHANNEL ? 1'b1 : setup_ff[TEMPSEL_BIT];
    assign outputRateSelect = setup_ff[RATE_MSB:RATE_LSB];
    assign filterBandwidthSelect = setup_ff[BANDWIDTH_BIT];
    assign softRestart = link.restartPulse;
    assign restartBusy = link.resetOn;
endmodule // adc_config_status_lock_regs
`default_nettype wire

//--- test/converter_side_model.sv
// converter-side sources: free-running sync counter, clock and ready sources
// assumes the register group's clock and reset
`timescale 1ns/10ps
`default_nettype none
module converter_side_model (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // sources toward the register group
    output logic [adc_regs_pkg::COUNT_W-1:0] syncCount,
    output logic clockSource,
    output logic sampleReady_n
);
    import adc_regs_pkg::*;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            syncCount <= 12'h000;
        end else begin
            syncCount <= syncCount + 12'h001;
        end
    end
    // ready differs from clock pattern so a swapped pin select shows
    assign clockSource = syncCount[0];
    assign sampleReady_n = ~&syncCount[2:1];
endmodule // converter_side_model
`default_nettype wire

//--- test/adc_regs_props.sv
// port assertions for the register group
// assumes one clock, bound into every instance
`timescale 1ns/10ps
`default_nettype none
module adc_regs_props (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // register port and outputs
    input wire logic [adc_regs_pkg::ADDR_W-1:0] regAddr,
    input wire logic regWrite,
    input wire logic [adc_regs_pkg::DATA_W-1:0] regWrData,
    input wire logic regRead,
    input wire logic [adc_regs_pkg::RDATA_W-1:0] regRdData,
    input wire logic converterShutdown,
    input wire logic [1:0] outputRateSelect,
    input wire logic filterBandwidthSelect,
    input wire logic softRestart,
    input wire logic restartBusy
);
    import adc_regs_pkg::*;
    logic [7:0] busyCnt;
    logic protExp_ff;
    logic cause_ff;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    always_ff @(posedge clk) begin
        if (sys_rst || !restartBusy) begin
            busyCnt <= 8'h00;
        end else begin
            busyCnt <= busyCnt + 8'h01;
        end
    end
    // protection as keys and restarts should leave it
    always_ff @(posedge clk) begin
        if (sys_rst || softRestart) begin
            protExp_ff <= 1'b0;
        end else if (regWrite && regAddr == LOCK_ADDR && regWrData == KEY_LOCK) begin
            protExp_ff <= 1'b1;
        end else if (regWrite && regAddr == LOCK_ADDR && regWrData == KEY_UNLOCK) begin
            protExp_ff <= 1'b0;
        end
    end
    // legal reason for setup outputs to move on the next edge; a protected write is none
    always_ff @(posedge clk) begin
        cause_ff <= sys_rst || softRestart || (regWrite && regAddr == SETUP_ADDR && !restartBusy && !protExp_ff);
    end
    restart_pulse_a: assert property (softRestart |=> !softRestart && restartBusy)
        else $error("restart pulse wrong");
    lock_read_a: assert property (regRead && regAddr == LOCK_ADDR |=> regRdData == 16'h0000)
        else $error("lock read not zero");
    snap_upper_a: assert property (regRead && regAddr == SNAPSHOT_ADDR |=> regRdData[15:12] == 4'h0)
        else $error("snapshot upper bits set");
    state_flags_a: assert property (regRead && regAddr == STATE_ADDR |=> regRdData[15:3] == 13'h0000
        && regRdData[RESETON_BIT] == $past(restartBusy))
        else $error("state flags wrong");
    prot_flag_a: assert property (regRead && regAddr == STATE_ADDR
        |=> regRdData[PROT_BIT] == $past(protExp_ff))
        else $error("protection flag wrong");
    setup_mirror_a: assert property (regRead && regAddr == SETUP_ADDR |=> regRdData[15:8] == 8'h00
        && !regRdData[1] && regRdData[RATE_MSB:RATE_LSB] == $past(outputRateSelect)
        && regRdData[SHUTDOWN_BIT] == $past(converterShutdown))
        else $error("setup readback wrong");
    change_cause_a: assert property (
        $changed({converterShutdown, outputRateSelect, filterBandwidthSelect}) |-> cause_ff)
        else $error("setup changed without write");
    busy_blocks_a: assert property (regWrite && regAddr == SETUP_ADDR && restartBusy
        |=> !softRestart && $stable({converterShutdown, outputRateSelect}))
        else $error("setup written while busy");
    busy_length_a: assert property ($fell(restartBusy)
        |-> busyCnt >= RESET_CYCLES - 1 && busyCnt <= RESET_CYCLES + 1)
        else $error("busy length wrong");
endmodule // adc_regs_props
bind adc_config_status_lock_regs adc_regs_props u_props (.clk(clk), .sys_rst(sys_rst), .regAddr(regAddr),
    .regWrite(regWrite), .regWrData(regWrData), .regRead(regRead), .regRdData(regRdData),
    .converterShutdown(converterShutdown),
    .outputRateSelect(outputRateSelect), .filterBandwidthSelect(filterBandwidthSelect),
    .softRestart(softRestart), .restartBusy(restartBusy));
`default_nettype wire

//--- test/tb_top.sv
// self-checking bench for the register group
// assumes the converter-side model drives counter and pin sources
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import adc_regs_pkg::*;
    logic clk = 1'b0, sys_rst = 1'b1, regWrite = 1'b0, regRead = 1'b0, snapCapture = 1'b0;
    logic [ADDR_W-1:0] regAddr = 5'h00;
    logic [DATA_W-1:0] regWrData = 8'h00;
    logic [RDATA_W-1:0] regRdData;
    logic [COUNT_W-1:0] syncCount, expSnap = 12'h000;
    logic regRdValid, sampleReady_n, clockSource, pin, shut, temp, bw, restart, busy, lastClk, lastRdy, temp2;
    logic [1:0] rate;
    int failCount = 0, comparisons = 0;
    initial forever #5 clk = ~clk;
    always @(posedge clk) begin
        lastClk <= clockSource;
        lastRdy <= sampleReady_n;
        if (snapCapture) expSnap <= syncCount;
    end
    converter_side_model u_model (.clk(clk), .sys_rst(sys_rst), .syncCount(syncCount),
        .clockSource(clockSource), .sampleReady_n(sampleReady_n));
    adc_config_status_lock_regs u_dut (.clk(clk), .sys_rst(sys_rst), .regAddr(regAddr), .regWrite(regWrite),
        .regWrData(regWrData), .regRead(regRead), .regRdData(regRdData), .regRdValid(regRdValid),
        .syncCount(syncCount), .snapCapture(snapCapture), .sampleReady_n(sampleReady_n),
        .clockSource(clockSource), .sharedClockOrReadyPin(pin), .converterShutdown(shut),
        .secondChannelTemp(temp), .outputRateSelect(rate), .filterBandwidthSelect(bw),
        .softRestart(restart), .restartBusy(busy));
    // two-channel build shares the stimulus; only its forced temperature select is compared
    adc_config_status_lock_regs #(.TWO_CHANNEL(1'b1)) u_dut_two (.clk(clk), .sys_rst(sys_rst),
        .regAddr(regAddr), .regWrite(regWrite), .regWrData(regWrData), .regRead(regRead), .regRdData(),
        .regRdValid(), .syncCount(syncCount), .snapCapture(snapCapture), .sampleReady_n(sampleReady_n),
        .clockSource(clockSource), .sharedClockOrReadyPin(), .converterShutdown(),
        .secondChannelTemp(temp2), .outputRateSelect(), .filterBandwidthSelect(),
        .softRestart(), .restartBusy());
    task automatic summarize();
        if (failCount == 0 && comparisons > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            failCount++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk);
        regAddr <= a;
        regWrData <= d;
        regWrite <= 1'b1;
        @(posedge clk);
        regWrite <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a, input logic [15:0] exp);
        @(posedge clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk);
        regRead <= 1'b0;
        #1;
        chk(regRdValid, 16'h0001);
        chk(regRdData, exp);
    endtask
    // pin lags its source by one cycle
    task automatic pinChk(input logic sel);
        repeat (4) begin
            @(posedge clk);
            #1;
            chk(pin, sel ? lastClk : lastRdy);
        end
    endtask
    task automatic waitIdle();
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 300) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (n == 300) begin
            failCount++;
            summarize();
        end
    endtask
    initial begin
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        rd(SETUP_ADDR, 16'h0000);
        rd(STATE_ADDR, 16'h0001);
        rd(SNAPSHOT_ADDR, 16'h0000);
        // setup writes are dropped while the reset flag stands
        wr(SETUP_ADDR, 8'h44);
        rd(SETUP_ADDR, 16'h0000);
        waitIdle();
        rd(STATE_ADDR, 16'h0000);
        wr(SETUP_ADDR, 8'hbf);
        chk({shut, temp, rate, bw}, 16'h001f);
        rd(SETUP_ADDR, 16'h00bd);
        rd(STATE_ADDR, 16'h0002);
        wr(SETUP_ADDR, 8'h01);
        pinChk(1'b1);
        wr(SETUP_ADDR, 8'h00);
        pinChk(1'b0);
        for (int r = 0; r < 4; r++) begin
            wr(SETUP_ADDR, 8'(r << 4));
            chk(rate, 16'(r));
        end
        rd(STATE_ADDR, 16'h0002);
        wr(LOCK_ADDR, KEY_LOCK);
        rd(STATE_ADDR, 16'h0004);
        wr(SETUP_ADDR, 8'h84);
        rd(SETUP_ADDR, 16'h0030);
        wr(LOCK_ADDR, 8'h55);
        rd(LOCK_ADDR, 16'h0000);
        rd(STATE_ADDR, 16'h0004);
        wr(LOCK_ADDR, KEY_UNLOCK);
        wr(SETUP_ADDR, 8'h84);
        rd(SETUP_ADDR, 16'h0084);
        @(posedge clk);
        snapCapture <= 1'b1;
        @(posedge clk);
        snapCapture <= 1'b0;
        #1;
        rd(SNAPSHOT_ADDR, {4'h0, expSnap});
        wr(SETUP_ADDR, 8'h40);
        chk(restart, 16'h0001);
        @(posedge clk);
        #1;
        chk({restart, busy}, 16'h0001);
        rd(SETUP_ADDR, 16'h0000);
        rd(SNAPSHOT_ADDR, 16'h0000);
        waitIdle();
        chk({temp, temp2}, 16'h0001);
        // mid-run reset while locked must drop protection and setup
        wr(SETUP_ADDR, 8'h0c);
        wr(LOCK_ADDR, KEY_LOCK);
        @(posedge clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        rd(STATE_ADDR, 16'h0001);
        rd(SETUP_ADDR, 16'h0000);
        waitIdle();
        summarize();
    end
endmodule // tb_top
`default_nettype wire
